// ==== pkg/int_gate_defines.vh ====
/*
 Register offsets, field positions and reset values of the interrupt enable gating stage.
 Assumes inclusion by bare name from design and bench files.
*/
`ifndef INT_GATE_DEFINES_VH
`define INT_GATE_DEFINES_VH

// Byte offsets of the registers on the register bus.
`define OFS_VECTOR_ENABLE_LOW   8'h88
`define OFS_VECTOR_ENABLE_HIGH  8'ha8
`define OFS_GLOBAL_GATE         8'he8
`define OFS_SOURCE_SELECT_LOW   8'he4
`define OFS_SOURCE_SELECT_HIGH  8'he5
`define OFS_PENDING_STATUS      8'hf0
`define OFS_FORWARD_STATUS      8'hf4

// Field positions inside the global gate register.
`define BIT_GLOBAL_GATE_FLAG    0
`define BIT_PIN_REQUEST_CLEAR   1

// Reset values.
`define RST_VECTOR_ENABLE       8'h00
`define RST_SOURCE_SELECT       8'h00
`define RST_GLOBAL_GATE         1'b0

// AXI4-Lite response codes.
`define RESP_OKAY               2'b00
`define RESP_SLVERR             2'b10

`endif

// ==== src/interrupt_enable_gating.v ====
/*
 Enable gating stage between sixteen interrupt sources and the processor interrupt logic,
 with an AXI4-Lite register slave. Assumes module request groups arrive already combined
 per vector on clk, and pin requests arrive from outside and are synchronised here.
*/
//
// Function
// R1 - Global flag set forwards all enabled requests.
// R2 - Global flag clear masks every request.
// R3 - Software pulses pin clear before pin enable.
// R4 - Vector enable bit opens or closes path.
// R5 - Low bit 7 gates timer 1 or pin.
// R6 - Low bit 6 gates serial 1 or pin.
// R7 - Low bit 5 gates serial 0 or pin.
// R8 - Low bit 4 gates port watch 0.
// R9 - Low bit 3 gates timer or pin.
// R10 - Low bit 2 gates SPI receive or pin.
// R11 - Low bit 1 gates SPI transmit or pin.
// R12 - Low bit 0 gates pin only.
// R13 - High bit 7 gates port watch 1.
// R14 - High bit 6 gates watchdog and arithmetic.
// R15 - High bit 5 gates upper PWM timers.
// R16 - High bit 4 gates lower PWM timers.
// R17 - High bit 3 gates width counters.
// R18 - High bit 2 gates arbitration and collisions.
// R19 - High bit 1 gates two wire requests.
// R20 - High bit 0 gates timer 2 or pin.
// R21 - Source select chooses module or pin.
// R22 - Pin sensitivity stays level for modules.
// R23 - Forward equals global AND enable AND source.
`timescale 1ns/1ps
`include "int_gate_defines.vh"

module interrupt_enable_gating #(
  parameter ADDR_WIDTH = 8
) (
  // Clock and reset.
  input  wire                  clk,
  input  wire                  sys_rst,
  // AXI4-Lite write address channel.
  input  wire [ADDR_WIDTH-1:0] s_axi_awaddr,
  input  wire                  s_axi_awvalid,
  output wire                  s_axi_awready,
  // AXI4-Lite write data channel.
  input  wire [31:0]           s_axi_wdata,
  input  wire [3:0]            s_axi_wstrb,
  input  wire                  s_axi_wvalid,
  output wire                  s_axi_wready,
  // AXI4-Lite write response channel.
  output wire [1:0]            s_axi_bresp,
  output wire                  s_axi_bvalid,
  input  wire                  s_axi_bready,
  // AXI4-Lite read address channel.
  input  wire [ADDR_WIDTH-1:0] s_axi_araddr,
  input  wire                  s_axi_arvalid,
  output wire                  s_axi_arready,
  // AXI4-Lite read data channel.
  output wire [31:0]           s_axi_rdata,
  output wire [1:0]            s_axi_rresp,
  output wire                  s_axi_rvalid,
  input  wire                  s_axi_rready,
  // Module request groups, one combined level per vector, on clk.
  input  wire [15:0]           module_request,
  // Pin requests after polarity and sensitivity logic, asynchronous.
  input  wire [15:0]           pin_request,
  // Gated requests toward the processor interrupt logic.
  output wire [15:0]           forwarded_request,
  // One-cycle pulse asking the pin logic to clear its pending flags.
  output wire                  pin_request_clear
);

  // Register state.
  reg  [7:0]  vector_enable_low_q;
  reg  [7:0]  vector_enable_high_q;
  reg  [7:0]  source_select_low_q;
  reg  [7:0]  source_select_high_q;
  reg         global_gate_flag_q;
  reg         pin_clear_q;
  reg  [15:0] pin_meta_q;
  reg  [15:0] pin_sync_q;
  reg  [15:0] forward_q;

  // Bus slave state.
  reg                  aw_held_q;
  reg [ADDR_WIDTH-1:0] aw_addr_q;
  reg                  w_held_q;
  reg [31:0]           w_data_q;
  reg [3:0]            w_strb_q;
  reg                  bvalid_q;
  reg [1:0]            bresp_q;
  reg                  rvalid_q;
  reg [31:0]           rdata_q;
  reg [1:0]            rresp_q;

  wire [15:0] enable_all;
  wire [15:0] select_all;
  wire [15:0] pending;
  wire        do_write;
  wire        do_read;

  // Returns one when the offset names a mapped register.
  function mapped;
    input [ADDR_WIDTH-1:0] a;
    begin
      mapped = (a == `OFS_VECTOR_ENABLE_LOW)  || (a == `OFS_VECTOR_ENABLE_HIGH) ||
               (a == `OFS_GLOBAL_GATE)        || (a == `OFS_SOURCE_SELECT_LOW)  ||
               (a == `OFS_SOURCE_SELECT_HIGH) || (a == `OFS_PENDING_STATUS)     ||
               (a == `OFS_FORWARD_STATUS);
    end
  endfunction

  // Bits 7 to 0 of the low register gate vectors 7 to 0, the high register vectors 15 to 8.
  assign enable_all = {vector_enable_high_q, vector_enable_low_q};  // [R5] [R6] [R7] [R8] [R9] [R10] [R11] [R12] [R13] [R14] [R15] [R16] [R17] [R18] [R19] [R20]
  assign select_all = {source_select_high_q, source_select_low_q};

  // Vector 0 has no module, so it only ever sees its pin.
  assign pending = (select_all & pin_sync_q) |
                   (~select_all & {module_request[15:1], 1'b0});  // [R21] [R12]

  // Pin requests pass two flip-flops before use.
  always @(posedge clk) begin
    if (sys_rst) begin
      pin_meta_q <= 16'h0000;
      pin_sync_q <= 16'h0000;
    end else begin
      pin_meta_q <= pin_request;
      pin_sync_q <= pin_meta_q;
    end
  end

  // Gated request, refreshed every clock.
  always @(posedge clk) begin
    if (sys_rst) begin
      forward_q <= 16'h0000;
    end else begin
      forward_q <= {16{global_gate_flag_q}} & enable_all & pending;  // [R1] [R2] [R4] [R23]
    end
  end

  assign forwarded_request = forward_q;
  assign pin_request_clear = pin_clear_q;

  // Write address and data are taken in either order, then executed together.
  assign s_axi_awready = ~aw_held_q & ~bvalid_q;
  assign s_axi_wready  = ~w_held_q & ~bvalid_q;
  assign do_write      = aw_held_q & w_held_q & ~bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;

  always @(posedge clk) begin
    if (sys_rst) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= {ADDR_WIDTH{1'b0}};
      w_held_q  <= 1'b0;
      w_data_q  <= 32'h00000000;
      w_strb_q  <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held_q <= 1'b0;
        w_held_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= mapped(aw_addr_q) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Register writes; only byte lane 0 carries data. Pin clear is a self-clearing pulse.
  always @(posedge clk) begin
    if (sys_rst) begin
      vector_enable_low_q  <= `RST_VECTOR_ENABLE;
      vector_enable_high_q <= `RST_VECTOR_ENABLE;
      source_select_low_q  <= `RST_SOURCE_SELECT;
      source_select_high_q <= `RST_SOURCE_SELECT;
      global_gate_flag_q   <= `RST_GLOBAL_GATE;
      pin_clear_q          <= 1'b0;
    end else begin
      pin_clear_q <= 1'b0;
      if (do_write && w_strb_q[0]) begin
        case (aw_addr_q)
          `OFS_VECTOR_ENABLE_LOW: begin
            vector_enable_low_q <= w_data_q[7:0];  // [R4]
          end
          `OFS_VECTOR_ENABLE_HIGH: begin
            vector_enable_high_q <= w_data_q[7:0];  // [R4]
          end
          `OFS_SOURCE_SELECT_LOW: begin
            source_select_low_q <= w_data_q[7:0];  // [R21]
          end
          `OFS_SOURCE_SELECT_HIGH: begin
            source_select_high_q <= w_data_q[7:0];  // [R21]
          end
          `OFS_GLOBAL_GATE: begin
            global_gate_flag_q <= w_data_q[`BIT_GLOBAL_GATE_FLAG];  // [R1] [R2]
            pin_clear_q        <= w_data_q[`BIT_PIN_REQUEST_CLEAR];  // [R3]
          end
          default: begin
            pin_clear_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // Read channel: one read at a time, answered the cycle after the address is taken.
  assign s_axi_arready = ~rvalid_q;
  assign do_read       = s_axi_arvalid & ~rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  always @(posedge clk) begin
    if (sys_rst) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h00000000;
      rresp_q  <= `RESP_OKAY;
    end else if (do_read) begin
      rvalid_q <= 1'b1;
      rresp_q  <= mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
      case (s_axi_araddr)
        `OFS_VECTOR_ENABLE_LOW:  rdata_q <= {24'h000000, vector_enable_low_q};
        `OFS_VECTOR_ENABLE_HIGH: rdata_q <= {24'h000000, vector_enable_high_q};
        `OFS_SOURCE_SELECT_LOW:  rdata_q <= {24'h000000, source_select_low_q};
        `OFS_SOURCE_SELECT_HIGH: rdata_q <= {24'h000000, source_select_high_q};
        `OFS_GLOBAL_GATE:        rdata_q <= {31'h00000000, global_gate_flag_q};
        `OFS_PENDING_STATUS:     rdata_q <= {16'h0000, pending};
        `OFS_FORWARD_STATUS:     rdata_q <= {16'h0000, forward_q};
        default:                 rdata_q <= 32'h00000000;
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

endmodule // interrupt_enable_gating

// ==== dv/gate_props.sv ====
/* Port checker for the interrupt enable gating stage.
   Assumes a bind from the bench top file and a synchronous active-high reset. */
`timescale 1ns/1ps
module gate_props (
  // Clock and reset.
  input wire logic        clk,
  input wire logic        sys_rst,
  // Register bus handshakes.
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Requests in and out.
  input wire logic [15:0] module_request,
  input wire logic [15:0] pin_request,
  input wire logic [15:0] forwarded_request,
  input wire logic        pin_request_clear
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // Bus answers stand until taken and come at the stated latency.
  reset_quiet_a: assert property ($fell(sys_rst) |-> forwarded_request == 16'h0000 && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs not cleared by reset");
  write_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped early");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer changed early");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  clear_pulse_a: assert property (pin_request_clear |=> !pin_request_clear)
    else $error("clear pulse too long");

  // A forwarded request only rises where a module or a pin asked for it.
  forward_cause_a: assert property ((forwarded_request & ~$past(forwarded_request) & ~($past(module_request)
      | $past(pin_request, 2) | $past(pin_request, 3))) == 16'h0000)
    else $error("request forwarded without a source");
  vector_zero_a: assert property ($rose(forwarded_request[0]) |-> $past(pin_request[0], 2) || $past(pin_request[0], 3))
    else $error("vector zero forwarded without its pin");
endmodule // gate_props

// ==== dv/source_model.sv ====
/* Model of the peripheral modules and interrupt pins that feed the gating stage.
   Assumes the bench sets wanted request levels on clk. */
`timescale 1ns/1ps
module source_model (
  // Clock.
  input  wire logic        clk,
  // Wanted request levels.
  input  wire logic [15:0] mod_want,
  input  wire logic [15:0] pin_want,
  // Requests toward the gating stage.
  output logic      [15:0] module_request = 16'h0000,
  output logic      [15:0] pin_request = 16'h0000
);
  // Module groups give level requests launched on clk.
  always @(posedge clk) begin
    module_request <= mod_want;
  end
  // Pins move between edges, with no relation to clk.
  always @(pin_want) begin
    pin_request <= #30 pin_want;
  end
endmodule // source_model

// ==== dv/tb.sv ====
/* Self-checking bench of the gating stage with its source model.
   Assumes the register map of int_gate_defines.vh. */
`timescale 1ns/1ps
`include "int_gate_defines.vh"
module tb;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rd;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [15:0] mod_want = 16'h0000, pin_want = 16'h0000;
  logic [3:0]  wstrb = 4'hf;
  logic [1:0]  rsp;
  wire  [15:0] module_request, pin_request, forwarded_request;
  wire  [31:0] rdata;
  wire  [1:0]  bresp, rresp;
  wire         awready, wready, bvalid, arready, rvalid, pin_request_clear;
  int          mismatches = 0, check_count = 0, clr_seen = 0;

  source_model src (.clk(clk), .mod_want(mod_want), .pin_want(pin_want), .module_request(module_request),
    .pin_request(pin_request));
  interrupt_enable_gating uut (.clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .module_request(module_request), .pin_request(pin_request),
    .forwarded_request(forwarded_request), .pin_request_clear(pin_request_clear));

  // Clock, and a count of clear pulses.
  initial forever #50 clk = ~clk;
  always @(posedge clk) if (pin_request_clear === 1'b1) clr_seen++;

  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Write with address and data together; the response is taken one cycle late.
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw;
    {awaddr, wdata, awvalid, wvalid} <= {a, d, 2'b11};
    do begin
      @(negedge clk);
      {ta, tw} = {awvalid && awready, wvalid && wready};
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end while (awvalid && !ta || wvalid && !tw);
    do @(negedge clk); while (!bvalid);
    rsp = bresp;
    @(posedge clk);
    bready <= 1'b1;
    @(posedge clk);
    bready <= 1'b0;
  endtask
  task rd_reg(input logic [7:0] a);
    {araddr, arvalid} <= {a, 1'b1};
    do @(negedge clk); while (!arready);
    @(posedge clk);
    arvalid <= 1'b0;
    do @(negedge clk); while (!rvalid);
    {rd, rsp} = {rdata, rresp};
    @(posedge clk);
    rready <= 1'b1;
    @(posedge clk);
    rready <= 1'b0;
  endtask
  task fwd(input string nm, input logic [15:0] e);
    repeat (6) @(negedge clk);
    chk(nm, {16'h0, e}, {16'h0, forwarded_request});
    @(posedge clk);
  endtask

  // Enable, gate and low source select registers come up cleared, unmapped places answer with an error, the clear bit pulses once.
  task t_regs;
    logic [7:0] ofs [4];
    ofs = '{`OFS_VECTOR_ENABLE_LOW, `OFS_VECTOR_ENABLE_HIGH, `OFS_GLOBAL_GATE, `OFS_SOURCE_SELECT_LOW};
    foreach (ofs[i]) begin
      rd_reg(ofs[i]);
      chk("reset value", 32'h0, rd);
    end
    rd_reg(8'h10);
    chk("unmapped read", {30'h0, `RESP_SLVERR}, {30'h0, rsp});
    wr(8'h10, 32'h1);
    chk("unmapped write", {30'h0, `RESP_SLVERR}, {30'h0, rsp});
    wr(`OFS_GLOBAL_GATE, 32'h3);
    rd_reg(`OFS_GLOBAL_GATE);
    chk("global gate", 32'h1, rd);
    chk("clear pulses", 32'h1, 32'(clr_seen));
  endtask
  // Module sources pass only with the global flag, and each enable bit except bit 0 opens its own vector.
  task t_modules;
    logic [15:0] e;
    mod_want <= 16'hffff;
    wr(`OFS_VECTOR_ENABLE_LOW, 32'hff);
    wr(`OFS_VECTOR_ENABLE_HIGH, 32'hff);
    wr(`OFS_GLOBAL_GATE, 32'h0);
    fwd("all masked", 16'h0000);
    wr(`OFS_GLOBAL_GATE, 32'h1);
    fwd("all open", 16'hfffe);
    for (int i = 0; i < 16; i++) begin
      e = 16'h0001 << i;
      wr(`OFS_VECTOR_ENABLE_LOW, {24'h0, e[7:0]});
      wr(`OFS_VECTOR_ENABLE_HIGH, {24'h0, e[15:8]});
      fwd("one vector", e & 16'hfffe);
    end
  endtask
  // With pin sources chosen, modules are ignored and pins pass, vector zero included.
  task t_pins;
    wr(`OFS_VECTOR_ENABLE_LOW, 32'hff);
    wr(`OFS_VECTOR_ENABLE_HIGH, 32'hff);
    wr(`OFS_SOURCE_SELECT_LOW, 32'hff);
    wr(`OFS_SOURCE_SELECT_HIGH, 32'hff);
    fwd("pins idle", 16'h0000);
    pin_want <= 16'h8001;
    fwd("pins high", 16'h8001);
    rd_reg(`OFS_PENDING_STATUS);
    chk("pending status", 32'h00008001, rd);
    rd_reg(`OFS_FORWARD_STATUS);
    chk("forward status", 32'h00008001, rd);
    wr(`OFS_VECTOR_ENABLE_LOW, 32'h00);
    fwd("pin zero closed", 16'h8000);
    wr(`OFS_GLOBAL_GATE, 32'h0);
    fwd("pins masked", 16'h0000);
  endtask
  // A write without byte lane 0 changes nothing, and a reset in mid-run clears the low enable register.
  task t_reset;
    wr(`OFS_VECTOR_ENABLE_LOW, 32'h5a);
    wstrb <= 4'he;
    wr(`OFS_VECTOR_ENABLE_LOW, 32'hff);
    wstrb <= 4'hf;
    rd_reg(`OFS_VECTOR_ENABLE_LOW);
    chk("lane zero off", 32'h5a, rd);
    wr(`OFS_GLOBAL_GATE, 32'h1);
    fwd("open before reset", 16'h8000);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rd_reg(`OFS_VECTOR_ENABLE_LOW);
    chk("enable after reset", 32'h0, rd);
    fwd("reset masked", 16'h0000);
  endtask

  task results;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Main sequence, and a watchdog well beyond its length.
  initial begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    t_regs;
    t_modules;
    t_pins;
    t_reset;
    results;
  end
  initial begin
    repeat (3000) @(posedge clk);
    mismatches++;
    results;
  end
endmodule // tb

bind interrupt_enable_gating gate_props props (.clk, .sys_rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .module_request, .pin_request, .forwarded_request, .pin_request_clear);
